// [verilog/can_msgbuf.sv]
// Message buffer storage for a CAN controller: three transmit buffers, one receive buffer,
// local priority selection and a bit-time stamping counter.
// Assumes the protocol engine supplies bit ticks, start-of-frame requests and acknowledge pulses.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Standard identifier: eleven bits, upper eight in first byte, lower three high.
// - On the bus, a smaller identifier value wins arbitration.
// - Bit 4 of second identifier byte is the remote-request flag; zero is data.
// - Bit 3 selects standard (0) or extended (1) identifier format.
// - Unused identifier bits read zero; software must ignore them.
// - Each buffer holds eight payload bytes.
// - Length code in bits 3:0, binary count zero to eight.
// - Remote frames send the length code as written but no payload bytes.
// - Before start of frame, only buffers with cleared empty flag compete.
// - The competing buffer with smallest local priority is chosen.
// - Ties on local priority go to the lowest buffer index.
// - Priority register accessible only when selected buffer is empty.
// - With stamping on, counter value captured into active buffer on acknowledge.
// - Stamp counter free-runs on bit ticks; wrap is not flagged.
// - Stamp counter held at zero in initialization mode.
// - Stamp bytes read-only; valid while buffer is empty and selected.
// - Set empty flag means buffer free; clearing it queues the buffer.
// - Buffer select register decides which transmit buffer the window shows.
// - Three transmit buffers, each with full private storage.
module can_msgbuf
	import can_msgbuf_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic bit_tick,
	input wire logic sof_request,
	input wire logic tx_ack,
	input wire logic [2:0] tx_byte_idx,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	output logic [1:0] tx_index,
	output logic [10:0] tx_id,
	output logic tx_rtr,
	output logic tx_ide,
	output logic [3:0] tx_dlc,
	output logic [3:0] tx_byte_count,
	input wire logic arb_sample,
	input wire logic [10:0] arb_bus_id,
	output logic arb_lost,
	input wire logic rx_hdr_we,
	input wire logic [10:0] rx_id,
	input wire logic rx_rtr,
	input wire logic rx_ide,
	input wire logic [3:0] rx_dlc,
	input wire logic rx_byte_we,
	input wire logic [2:0] rx_byte_idx,
	input wire logic [7:0] rx_byte,
	input wire logic rx_ack,
	output logic [NUM_TX-1:0] tx_empty,
	output logic init_mode
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [NUM_TX-1:0][7:0] tx_idh;
		logic [NUM_TX-1:0][4:0] tx_idl;
		logic [NUM_TX-1:0][NUM_BYTES-1:0][7:0] tx_data;
		logic [NUM_TX-1:0][3:0] tx_dlc;
		logic [NUM_TX-1:0][7:0] tx_rank;
		logic [NUM_TX-1:0][STAMP_W-1:0] tx_stamp;
		logic [NUM_TX-1:0] txe;
		logic [NUM_TX-1:0] sel;
		logic ctl_init;
		logic ctl_stamp;
		logic [7:0] rx_idh;
		logic [4:0] rx_idl;
		logic [NUM_BYTES-1:0][7:0] rx_data;
		logic [3:0] rx_dlc;
		logic [STAMP_W-1:0] rx_stamp;
		logic [STAMP_W-1:0] timer;
		logic active;
		logic [1:0] act_idx;
		logic [10:0] out_id;
		logic out_rtr;
		logic out_ide;
		logic [3:0] out_dlc;
		logic [3:0] out_count;
		logic [7:0] out_byte;
		logic lost;
		logic [7:0] rdata;
	} state_s;

	state_s st_q;
	state_s st_d;

	// ==========================================================
	// Helpers
	function automatic logic [1:0] low_index(input logic [NUM_TX-1:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = NUM_TX - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [NUM_TX-1:0] low_onehot(input logic [NUM_TX-1:0] v);
		return v & (~v + NUM_TX'(1));
	endfunction

	logic [1:0] sel_idx;
	logic win_ok;
	logic [1:0] best_idx;
	logic best_found;
	logic [7:0] best_rank;

	always_comb
	begin
		sel_idx = low_index(st_q.sel);
		win_ok = (st_q.sel != '0) && st_q.txe[sel_idx];
	end

	// Local priority selection over queued buffers
	always_comb
	begin
		best_idx = 2'h0;
		best_found = 1'b0;
		best_rank = 8'hFF;
		for (int i = 0; i < NUM_TX; i++)
		begin
			if (!st_q.txe[i])
			begin
				if (!best_found || st_q.tx_rank[i] < best_rank)
				begin
					best_idx = 2'(i);
					best_rank = st_q.tx_rank[i];
					best_found = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [3:0] dlc_sel;
		logic [7:0] rd_val;
		dlc_sel = 4'h0;
		rd_val = 8'h00;
		st_d = st_q;

		// Stamp counter
		if (st_q.ctl_init)
		begin
			st_d.timer = '0;
		end
		else if (bit_tick)
		begin
			st_d.timer = st_q.timer + STAMP_W'(1);
		end

		// Register writes
		if (reg_wr)
		begin
			if (win_ok && reg_addr[5:3] == PAGE_TX_DATA)
			begin
				st_d.tx_data[sel_idx][reg_addr[2:0]] = reg_wdata;
			end
			else
			begin
				case (reg_addr)
					OFF_TX_ID_HIGH:
					begin
						if (win_ok)
						begin
							st_d.tx_idh[sel_idx] = reg_wdata;
						end
					end
					OFF_TX_ID_LOW:
					begin
						if (win_ok)
						begin
							st_d.tx_idl[sel_idx] = reg_wdata[7:IDE_BIT];
						end
					end
					OFF_TX_LENGTH:
					begin
						if (win_ok)
						begin
							st_d.tx_dlc[sel_idx] = reg_wdata[3:0];
						end
					end
					OFF_TX_PRIORITY:
					begin
						if (win_ok)
						begin
							st_d.tx_rank[sel_idx] = reg_wdata;
						end
					end
					OFF_TX_FLAGS:
					begin
						st_d.txe = st_q.txe & ~reg_wdata[NUM_TX-1:0];
					end
					OFF_TX_SELECT:
					begin
						st_d.sel = low_onehot(reg_wdata[NUM_TX-1:0] & st_q.txe);
					end
					OFF_CONTROL:
					begin
						st_d.ctl_init = reg_wdata[CTL_INIT_BIT];
						st_d.ctl_stamp = reg_wdata[CTL_STAMP_BIT];
					end
					default:
					begin
					end
				endcase
			end
		end

		// Start of frame: pick the next buffer
		if (sof_request)
		begin
			st_d.active = best_found;
			st_d.act_idx = best_idx;
			st_d.lost = 1'b0;
			dlc_sel = st_q.tx_dlc[best_idx];
			st_d.out_id = {st_q.tx_idh[best_idx], st_q.tx_idl[best_idx][4:2]};
			st_d.out_rtr = st_q.tx_idl[best_idx][RTR_BIT-IDE_BIT];
			st_d.out_ide = st_q.tx_idl[best_idx][0];
			st_d.out_dlc = dlc_sel;
			if (st_q.tx_idl[best_idx][RTR_BIT-IDE_BIT])
			begin
				st_d.out_count = 4'h0;
			end
			else if (dlc_sel > MAX_PAYLOAD)
			begin
				st_d.out_count = MAX_PAYLOAD;
			end
			else
			begin
				st_d.out_count = dlc_sel;
			end
		end

		// Arbitration compare against the identifier seen on the bus
		if (arb_sample && st_q.active && arb_bus_id < st_q.out_id)
		begin
			st_d.lost = 1'b1;
		end

		st_d.out_byte = st_q.tx_data[st_q.act_idx][tx_byte_idx];

		// Acknowledged transmission frees the buffer; set wins over clear
		if (tx_ack && st_q.active)
		begin
			st_d.txe[st_q.act_idx] = 1'b1;
			st_d.active = 1'b0;
			if (st_q.ctl_stamp)
			begin
				st_d.tx_stamp[st_q.act_idx] = st_q.timer;
			end
		end

		// Receive side capture
		if (rx_hdr_we)
		begin
			st_d.rx_idh = rx_id[10:3];
			st_d.rx_idl = {rx_id[2:0], rx_rtr, rx_ide};
			st_d.rx_dlc = rx_dlc;
		end
		if (rx_byte_we)
		begin
			st_d.rx_data[rx_byte_idx] = rx_byte;
		end
		if (rx_ack && st_q.ctl_stamp)
		begin
			st_d.rx_stamp = st_q.timer;
		end

		// Register reads, data one cycle later; unmapped reads return zero
		if (reg_rd)
		begin
			if (reg_addr[5:3] == PAGE_TX_DATA)
			begin
				rd_val = win_ok ? st_q.tx_data[sel_idx][reg_addr[2:0]] : 8'h00;
			end
			else if (reg_addr[5:3] == PAGE_RX_DATA)
			begin
				rd_val = st_q.rx_data[reg_addr[2:0]];
			end
			else
			begin
				case (reg_addr)
					OFF_TX_ID_HIGH: rd_val = win_ok ? st_q.tx_idh[sel_idx] : 8'h00;
					OFF_TX_ID_LOW: rd_val = win_ok ? {st_q.tx_idl[sel_idx], 3'h0} : 8'h00;
					OFF_TX_LENGTH: rd_val = win_ok ? {4'h0, st_q.tx_dlc[sel_idx]} : 8'h00;
					OFF_TX_PRIORITY: rd_val = win_ok ? st_q.tx_rank[sel_idx] : 8'h00;
					OFF_TX_STAMP_HIGH: rd_val = win_ok ? st_q.tx_stamp[sel_idx][15:8] : 8'h00;
					OFF_TX_STAMP_LOW: rd_val = win_ok ? st_q.tx_stamp[sel_idx][7:0] : 8'h00;
					OFF_RX_ID_HIGH: rd_val = st_q.rx_idh;
					OFF_RX_ID_LOW: rd_val = {st_q.rx_idl, 3'h0};
					OFF_RX_LENGTH: rd_val = {4'h0, st_q.rx_dlc};
					OFF_RX_STAMP_HIGH: rd_val = st_q.rx_stamp[15:8];
					OFF_RX_STAMP_LOW: rd_val = st_q.rx_stamp[7:0];
					OFF_TX_FLAGS: rd_val = {5'h00, st_q.txe};
					OFF_TX_SELECT: rd_val = {5'h00, st_q.sel};
					OFF_CONTROL: rd_val = {6'h00, st_q.ctl_stamp, st_q.ctl_init};
					OFF_STATUS: rd_val = {4'h0, st_q.lost, st_q.act_idx, st_q.active};
					default: rd_val = 8'h00;
				endcase
			end
		end
		st_d.rdata = rd_val;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
			st_q.txe <= TXE_RESET;
			st_q.ctl_init <= CTL_INIT_RESET;
			st_q.ctl_stamp <= CTL_STAMP_RESET;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = st_q.rdata;
	assign tx_byte = st_q.out_byte;
	assign tx_valid = st_q.active;
	assign tx_index = st_q.act_idx;
	assign tx_id = st_q.out_id;
	assign tx_rtr = st_q.out_rtr;
	assign tx_ide = st_q.out_ide;
	assign tx_dlc = st_q.out_dlc;
	assign tx_byte_count = st_q.out_count;
	assign arb_lost = st_q.lost;
	assign tx_empty = st_q.txe;
	assign init_mode = st_q.ctl_init;

endmodule

`default_nettype wire

// [shared/can_msgbuf_pkg.sv]
// Package for the CAN message buffer block: register map, field positions, reset values.
// Assumes a byte-wide register port and three transmit buffers plus one receive foreground buffer.
package can_msgbuf_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 6;
	localparam int NUM_TX = 3;
	localparam int NUM_BYTES = 8;
	localparam int STAMP_W = 16;

	// ==========================================================
	// Transmit window (shows the selected transmit buffer)
	localparam logic [5:0] OFF_TX_ID_HIGH = 6'h00;
	localparam logic [5:0] OFF_TX_ID_LOW = 6'h01;
	localparam logic [5:0] OFF_TX_LENGTH = 6'h04;
	localparam logic [5:0] OFF_TX_PRIORITY = 6'h05;
	localparam logic [5:0] OFF_TX_STAMP_HIGH = 6'h06;
	localparam logic [5:0] OFF_TX_STAMP_LOW = 6'h07;
	localparam logic [2:0] PAGE_TX_DATA = 3'h1;

	// ==========================================================
	// Receive window (foreground receive buffer)
	localparam logic [5:0] OFF_RX_ID_HIGH = 6'h10;
	localparam logic [5:0] OFF_RX_ID_LOW = 6'h11;
	localparam logic [5:0] OFF_RX_LENGTH = 6'h14;
	localparam logic [5:0] OFF_RX_STAMP_HIGH = 6'h16;
	localparam logic [5:0] OFF_RX_STAMP_LOW = 6'h17;
	localparam logic [2:0] PAGE_RX_DATA = 3'h3;

	// ==========================================================
	// Control and status
	localparam logic [5:0] OFF_TX_FLAGS = 6'h20;
	localparam logic [5:0] OFF_TX_SELECT = 6'h21;
	localparam logic [5:0] OFF_CONTROL = 6'h22;
	localparam logic [5:0] OFF_STATUS = 6'h23;

	// ==========================================================
	// Field positions
	localparam int ID_LOW_LSB = 5;
	localparam int RTR_BIT = 4;
	localparam int IDE_BIT = 3;
	localparam int CTL_INIT_BIT = 0;
	localparam int CTL_STAMP_BIT = 1;
	localparam logic [3:0] MAX_PAYLOAD = 4'h8;

	// ==========================================================
	// Reset values
	localparam logic [2:0] TXE_RESET = 3'h7;
	localparam logic CTL_INIT_RESET = 1'b1;
	localparam logic CTL_STAMP_RESET = 1'b0;

endpackage

// [verification/can_node_model.sv]
// Model of the bus side: the bit timing that the other nodes impose.
// Assumes the bench gates ticking with tick_on.
`timescale 1ns/1ps
`default_nettype none
module can_node_model
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic tick_on,
	output logic bit_tick
);
	logic [1:0] div_q;
	// ==========
	// Bit time of four clocks
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_q <= 2'h0;
			bit_tick <= 1'b0;
		end
		else
		begin
			div_q <= div_q + 2'h1;
			bit_tick <= tick_on && (div_q == 2'h3);
		end
	end
endmodule
`default_nettype wire

// [verification/can_msgbuf_checker.sv]
// Assertions on the transmit side of can_msgbuf.
// Assumes it is bound to every can_msgbuf instance.
`timescale 1ns/1ps
`default_nettype none
module can_msgbuf_checker
	import can_msgbuf_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic sof_request,
	input wire logic tx_ack,
	input wire logic arb_sample,
	input wire logic [10:0] arb_bus_id,
	input wire logic arb_lost,
	input wire logic tx_valid,
	input wire logic [1:0] tx_index,
	input wire logic [10:0] tx_id,
	input wire logic tx_rtr,
	input wire logic [3:0] tx_dlc,
	input wire logic [3:0] tx_byte_count,
	input wire logic [NUM_TX-1:0] tx_empty
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// ==========
	// Transmit checks
	sequence s_ack;
		tx_valid && tx_ack;
	endsequence
	property p_ack_frees;
		s_ack |=> !tx_valid && tx_empty[$past(tx_index)];
	endproperty
	a_ack_frees: assert property (p_ack_frees) else $error("ack left buffer busy");
	property p_none;
		sof_request && (tx_empty == 3'h7) |=> !tx_valid;
	endproperty
	a_none: assert property (p_none) else $error("sent with no buffer queued");
	property p_pick;
		sof_request && (tx_empty != 3'h7) |=> tx_valid && !tx_empty[tx_index];
	endproperty
	a_pick: assert property (p_pick) else $error("chosen buffer not queued");
	property p_rtr_none;
		tx_valid && tx_rtr |-> tx_byte_count == 4'h0;
	endproperty
	a_rtr_none: assert property (p_rtr_none) else $error("remote frame has payload");
	property p_count;
		tx_valid && !tx_rtr |-> tx_byte_count == ((tx_dlc > MAX_PAYLOAD) ? MAX_PAYLOAD : tx_dlc);
	endproperty
	a_count: assert property (p_count) else $error("wrong byte count");
	property p_lose;
		tx_valid && arb_sample && (arb_bus_id < tx_id) |=> arb_lost;
	endproperty
	a_lose: assert property (p_lose) else $error("smaller bus id did not win");
	property p_sof_clear;
		sof_request |=> !arb_lost;
	endproperty
	a_sof_clear: assert property (p_sof_clear) else $error("lost flag kept over start");
	property p_hold;
		tx_valid && !sof_request && !tx_ack |=> tx_valid && $stable(tx_id);
	endproperty
	a_hold: assert property (p_hold) else $error("chosen frame changed");
endmodule
bind can_msgbuf can_msgbuf_checker chk_u (.mclk, .arst_n, .sof_request, .tx_ack, .arb_sample, .arb_bus_id,
	.arb_lost, .tx_valid, .tx_index, .tx_id, .tx_rtr, .tx_dlc, .tx_byte_count, .tx_empty);
`default_nettype wire

// [verification/can_msgbuf_test.sv]
// Bench for can_msgbuf: register tasks, queued transmits, receive and stamping.
// Assumes the checker is bound and the node model makes bit ticks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end
module can_msgbuf_test
	import can_msgbuf_pkg::*;
;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [5:0] pl = 6'h00;
	logic [2:0] tx_byte_idx = 3'h5;
	logic [10:0] arb_bus_id = 11'h000;
	logic [10:0] rx_id = 11'h555;
	logic [3:0] rx_dlc = 4'h3;
	logic rx_rtr = 1'b1;
	logic rx_ide = 1'b0;
	logic [2:0] rx_byte_idx = 3'h7;
	logic [7:0] rx_byte = 8'hC3;
	logic tick_on = 1'b1;
	logic bit_tick, tx_valid, tx_rtr, tx_ide, arb_lost, init_mode;
	logic [7:0] reg_rdata, tx_byte;
	logic [1:0] tx_index;
	logic [10:0] tx_id;
	logic [3:0] tx_dlc, tx_byte_count;
	logic [NUM_TX-1:0] tx_empty;
	logic [15:0] tick_cnt = 16'h0000;
	logic [15:0] stamp;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [10:0] ids [3] = '{11'h123, 11'h2A5, 11'h7FF};
	logic [7:0] pri [3] = '{8'h05, 8'h03, 8'h03};
	logic [3:0] dlc [3] = '{4'hA, 4'h8, 4'h5};
	logic [3:0] cnt [3] = '{4'h8, 4'h0, 4'h8};
	logic rtr [3] = '{1'b0, 1'b0, 1'b1};
	logic ide [3] = '{1'b1, 1'b0, 1'b0};
	int picks [3] = '{1, 2, 0};

	can_msgbuf dut_u (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_tick,
		.sof_request(pl[0]), .tx_ack(pl[1]), .tx_byte_idx, .tx_byte, .tx_valid, .tx_index, .tx_id, .tx_rtr,
		.tx_ide, .tx_dlc, .tx_byte_count, .arb_sample(pl[2]), .arb_bus_id, .arb_lost, .rx_hdr_we(pl[3]),
		.rx_id, .rx_rtr, .rx_ide, .rx_dlc, .rx_byte_we(pl[4]), .rx_byte_idx, .rx_byte, .rx_ack(pl[5]),
		.tx_empty, .init_mode);
	can_node_model node_u (.mclk, .arst_n, .tick_on, .bit_tick);

	// ==========
	// Clock, tick monitor, timeout
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (init_mode)
			tick_cnt <= 16'h0000;
		else if (bit_tick)
			tick_cnt <= tick_cnt + 16'h0001;
		if (cyc == 4000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	// ==========
	// Tasks
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		`CHK(reg_rdata, e)
	endtask
	task automatic pulse(input logic [5:0] m);
		pl <= m;
		@(posedge mclk);
		pl <= 6'h00;
		@(posedge mclk);
	endtask
	function automatic logic [7:0] lo(input int i);
		return {ids[i][2:0], rtr[i], ide[i], 3'h0};
	endfunction
	task automatic tally_and_finish();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========
	// Sequence
	initial
	begin
		int b;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		`CHK(init_mode, 1'b1)
		rd(OFF_TX_FLAGS, 8'h07);
		rd(OFF_CONTROL, 8'h01);
		rd(OFF_TX_ID_HIGH, 8'h00);
		rd(6'h3F, 8'h00);
		wr(OFF_CONTROL, 8'h02);
		`CHK(init_mode, 1'b0)
		for (int i = 0; i < NUM_TX; i++)
		begin
			wr(OFF_TX_SELECT, 8'h01 << i);
			wr(OFF_TX_ID_HIGH, ids[i][10:3]);
			wr(OFF_TX_ID_LOW, lo(i));
			wr(OFF_TX_LENGTH, {4'h0, dlc[i]});
			wr(OFF_TX_PRIORITY, pri[i]);
			for (int j = 0; j < NUM_BYTES; j++)
				wr({PAGE_TX_DATA, j[2:0]}, {i[3:0], j[3:0]});
			rd(OFF_TX_ID_HIGH, ids[i][10:3]);
			rd(OFF_TX_ID_LOW, lo(i));
			rd(OFF_TX_LENGTH, {4'h0, dlc[i]});
			rd(OFF_TX_PRIORITY, pri[i]);
		end
		wr(OFF_TX_FLAGS, 8'h07);
		rd(OFF_TX_FLAGS, 8'h00);
		wr(OFF_TX_PRIORITY, 8'h00);
		rd(OFF_TX_PRIORITY, 8'h00);
		wr(OFF_TX_SELECT, 8'h07);
		rd(OFF_TX_SELECT, 8'h00);
		for (int k = 0; k < NUM_TX; k++)
		begin
			b = picks[k];
			pulse(6'h01);
			`CHK(tx_index, b[1:0])
			`CHK(tx_id, ids[b])
			`CHK(tx_rtr, rtr[b])
			`CHK(tx_ide, ide[b])
			`CHK(tx_dlc, dlc[b])
			`CHK(tx_byte_count, cnt[k])
			`CHK(arb_lost, 1'b0)
			if (k == 0)
			begin
				@(posedge mclk);
				`CHK(tx_byte, 8'h15)
				arb_bus_id <= ids[1];
				pulse(6'h04);
				`CHK(arb_lost, 1'b0)
				arb_bus_id <= ids[1] - 11'h001;
				pulse(6'h04);
				`CHK(arb_lost, 1'b1)
				rd(OFF_STATUS, 8'h0B);
				tick_on <= 1'b0;
				repeat (4) @(posedge mclk);
				stamp = tick_cnt;
			end
			pulse(6'h02);
			`CHK(tx_valid, 1'b0)
			`CHK(tx_empty[b], 1'b1)
			if (k == 0)
			begin
				wr(OFF_TX_SELECT, 8'h02);
				rd(OFF_TX_STAMP_HIGH, stamp[15:8]);
				rd(OFF_TX_STAMP_LOW, stamp[7:0]);
				wr(OFF_TX_STAMP_LOW, 8'h5A);
				rd(OFF_TX_STAMP_LOW, stamp[7:0]);
				tick_on <= 1'b1;
			end
		end
		pulse(6'h01);
		`CHK(tx_valid, 1'b0)
		tick_on <= 1'b0;
		repeat (4) @(posedge mclk);
		stamp = tick_cnt;
		pulse(6'h20);
		rd(OFF_RX_STAMP_HIGH, stamp[15:8]);
		rd(OFF_RX_STAMP_LOW, stamp[7:0]);
		wr(OFF_CONTROL, 8'h03);
		`CHK(init_mode, 1'b1)
		pulse(6'h38);
		rd(OFF_RX_ID_HIGH, 8'hAA);
		rd(OFF_RX_ID_LOW, 8'hB0);
		rd(OFF_RX_LENGTH, 8'h03);
		rd({PAGE_RX_DATA, 3'h7}, 8'hC3);
		rd(OFF_RX_STAMP_LOW, 8'h00);
		rd(OFF_RX_STAMP_HIGH, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
